// file: common/nvac_pkg.sv
// Constants for the nonvolatile byte access controller
package nvac_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEM_DEPTH = 512;
  localparam int unsigned IO_ADDR_W = 2;

  // Register select codes on the I/O port
  localparam logic [1:0] REG_ADDR_HIGH = 2'h0;
  localparam logic [1:0] REG_ADDR_LOW = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_CONTROL = 2'h3;

  // Control register field positions and the top address bit position
  localparam int unsigned BIT_READ_STROBE = 0;
  localparam int unsigned BIT_WRITE_STROBE = 1;
  localparam int unsigned BIT_WRITE_ARM = 2;
  localparam int unsigned BIT_IRQ_ENABLE = 3;
  localparam int unsigned BIT_ADDR_TOP = 8;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [8:0] ADDR_ZERO = 9'h000;

  // Arm window and CPU stall lengths in clock cycles
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] CNT3_ZERO = 3'h0;
  localparam logic [2:0] CNT3_ONE = 3'h1;

  // Self-timed programming: least time, rounded up to cycles
  localparam longint unsigned CLK_PERIOD_NS = 50;
  localparam longint unsigned PROG_TIME_MIN_NS = 7500000;
  localparam longint unsigned PROG_TIME_MAX_NS = 9000000;
  localparam longint unsigned PROG_CYCLES =
    (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W = 18;
  typedef logic [PROG_CNT_W-1:0] nvac_prog_cnt_t;
  localparam nvac_prog_cnt_t PROG_ZERO = 18'h00000;
  localparam nvac_prog_cnt_t PROG_ONE = 18'h00001;
endpackage

// file: rtl/nvac_mem.sv
// Byte store of 512 locations with registered read data
`timescale 1ns/1ps
module nvac_mem (
  input wire logic clock_i, // System clock
  input wire logic wr_en_i, // Write this cycle
  input wire logic [nvac_pkg::ADDR_W-1:0] wr_addr_i, // Write address
  input wire logic [nvac_pkg::DATA_W-1:0] wr_data_i, // Write data
  input wire logic rd_en_i, // Read this cycle
  input wire logic [nvac_pkg::ADDR_W-1:0] rd_addr_i, // Read address
  output logic [nvac_pkg::DATA_W-1:0] rd_data_o // Read data, next cycle
);
  import nvac_pkg::*;

  logic [DATA_W-1:0] store_mem [MEM_DEPTH];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      store_mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= store_mem[rd_addr_i];
    end
  end
endmodule // nvac_mem

// file: rtl/nvac_ctrl.sv
// CPU access controller for the on-chip nonvolatile byte store
`timescale 1ns/1ps
module nvac_ctrl #(
  parameter longint unsigned PROG_CYCLES = nvac_pkg::PROG_CYCLES
) (
  input wire logic clock_i, // System clock, 20 MHz
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire logic [nvac_pkg::IO_ADDR_W-1:0] io_sel_i, // Register select
  input wire logic io_wr_i, // Register write strobe
  input wire logic io_rd_i, // Register read strobe
  input wire logic [nvac_pkg::DATA_W-1:0] io_wdata_i, // Write data
  input wire logic cpu_global_ie_i, // Global interrupt enable bit
  input wire logic self_program_busy_i, // Flash self-programming active
  output logic [nvac_pkg::DATA_W-1:0] io_rdata_o, // Read data, next cycle
  output logic cpu_stall_o, // Holds the CPU
  output logic ready_irq_o // Ready interrupt request, level
);
  import nvac_pkg::*;

  localparam nvac_prog_cnt_t PROG_LOAD = nvac_prog_cnt_t'(PROG_CYCLES);

  function automatic logic reg_hit(input logic [IO_ADDR_W-1:0] sel,
                                   input logic [IO_ADDR_W-1:0] code);
    reg_hit = (sel == code);
  endfunction

  // Reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Access decode
  logic wr_addr_high, wr_addr_low, wr_data, wr_ctrl;
  logic rd_req, wr_req, arm_req;

  assign wr_addr_high = io_wr_i && reg_hit(io_sel_i, REG_ADDR_HIGH);
  assign wr_addr_low = io_wr_i && reg_hit(io_sel_i, REG_ADDR_LOW);
  assign wr_data = io_wr_i && reg_hit(io_sel_i, REG_DATA);
  assign wr_ctrl = io_wr_i && reg_hit(io_sel_i, REG_CONTROL);
  assign rd_req = wr_ctrl && io_wdata_i[BIT_READ_STROBE];
  assign wr_req = wr_ctrl && io_wdata_i[BIT_WRITE_STROBE];
  assign arm_req = wr_ctrl && io_wdata_i[BIT_WRITE_ARM];

  // Address holds no reset value; software must load it
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic busy_reg, busy_next;

  always_comb begin
    addr_next = addr_reg;
    if (!busy_reg && wr_addr_low) begin
      addr_next[DATA_W-1:0] = io_wdata_i;
    end
    if (!busy_reg && wr_addr_high) begin
      addr_next[BIT_ADDR_TOP] = io_wdata_i[0];
    end
  end

  always_ff @(posedge clock_i) begin
    addr_reg <= addr_next;
  end

  // Control and sequencing state
  logic [DATA_W-1:0] data_reg, data_next, prog_data_reg, prog_data_next;
  logic irq_en_reg, irq_en_next, arm_reg, arm_next;
  logic [2:0] arm_cnt_reg, arm_cnt_next, stall_cnt_reg, stall_cnt_next;
  nvac_prog_cnt_t prog_cnt_reg, prog_cnt_next;
  logic rd_pend_reg, rd_pend_next, stall_next, irq_next;
  logic [DATA_W-1:0] rdata_next, mem_rdata;
  logic start_write, start_read, prog_done;

  assign start_write = wr_req && arm_reg && !busy_reg && !self_program_busy_i;
  assign start_read = rd_req && !busy_reg;
  assign prog_done = busy_reg && (prog_cnt_reg == PROG_ONE);

  always_comb begin
    data_next = data_reg;
    prog_data_next = prog_data_reg;
    irq_en_next = irq_en_reg;
    arm_next = arm_reg;
    arm_cnt_next = arm_cnt_reg;
    busy_next = busy_reg;
    prog_cnt_next = prog_cnt_reg;
    rd_pend_next = 1'b0;
    stall_cnt_next = stall_cnt_reg;
    rdata_next = io_rdata_o;

    if (wr_data) begin
      data_next = io_wdata_i;
    end
    if (rd_pend_reg) begin
      data_next = mem_rdata;
    end

    if (wr_ctrl) begin
      irq_en_next = io_wdata_i[BIT_IRQ_ENABLE];
    end

    // Arm times out after four cycles
    if (arm_reg) begin
      arm_cnt_next = arm_cnt_reg - CNT3_ONE;
      if (arm_cnt_reg == CNT3_ONE) begin
        arm_next = 1'b0;
      end
    end
    if (arm_req) begin
      arm_next = 1'b1;
      arm_cnt_next = ARM_CYCLES;
    end

    if (start_write) begin
      busy_next = 1'b1;
      prog_cnt_next = PROG_LOAD;
      prog_data_next = data_reg;
    end else if (busy_reg) begin
      prog_cnt_next = prog_cnt_reg - PROG_ONE;
      if (prog_done) begin
        busy_next = 1'b0;
      end
    end

    if (start_read) begin
      rd_pend_next = 1'b1;
    end

    if (stall_cnt_reg != CNT3_ZERO) begin
      stall_cnt_next = stall_cnt_reg - CNT3_ONE;
    end
    if (start_read) begin
      stall_cnt_next = READ_STALL_CYCLES;
    end else if (start_write) begin
      stall_cnt_next = WRITE_STALL_CYCLES;
    end
    stall_next = (stall_cnt_next != CNT3_ZERO);

    irq_next = irq_en_next && cpu_global_ie_i && !busy_next;

    if (io_rd_i) begin
      unique case (io_sel_i)
        REG_ADDR_HIGH: rdata_next = {7'h00, addr_reg[BIT_ADDR_TOP]};
        REG_ADDR_LOW: rdata_next = addr_reg[DATA_W-1:0];
        REG_DATA: rdata_next = data_reg;
        REG_CONTROL: rdata_next = {4'h0, irq_en_reg, arm_reg, busy_reg,
                                   1'b0};
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= BYTE_ZERO;
      prog_data_reg <= BYTE_ZERO;
      irq_en_reg <= 1'b0;
      arm_reg <= 1'b0;
      arm_cnt_reg <= CNT3_ZERO;
      busy_reg <= 1'b0;
      prog_cnt_reg <= PROG_ZERO;
      rd_pend_reg <= 1'b0;
      stall_cnt_reg <= CNT3_ZERO;
      cpu_stall_o <= 1'b0;
      ready_irq_o <= 1'b0;
      io_rdata_o <= BYTE_ZERO;
    end else begin
      data_reg <= data_next;
      prog_data_reg <= prog_data_next;
      irq_en_reg <= irq_en_next;
      arm_reg <= arm_next;
      arm_cnt_reg <= arm_cnt_next;
      busy_reg <= busy_next;
      prog_cnt_reg <= prog_cnt_next;
      rd_pend_reg <= rd_pend_next;
      stall_cnt_reg <= stall_cnt_next;
      cpu_stall_o <= stall_next;
      ready_irq_o <= irq_next;
      io_rdata_o <= rdata_next;
    end
  end

  nvac_mem i_nvac_mem (
    .clock_i(clock_i),
    .wr_en_i(prog_done),
    .wr_addr_i(addr_reg),
    .wr_data_i(prog_data_reg),
    .rd_en_i(start_read),
    .rd_addr_i(addr_reg),
    .rd_data_o(mem_rdata)
  );

  property p_addr_high_zero;
    @(posedge clock_i) disable iff (!rst_n)
      io_rd_i && reg_hit(io_sel_i, REG_ADDR_HIGH) |=> io_rdata_o[7:1] == 7'h00;
  endproperty
  a_addr_high_zero: assert property (p_addr_high_zero)
    else $error("address high reserved bits not zero");

  property p_ctrl_reserved;
    @(posedge clock_i) disable iff (!rst_n)
      io_rd_i && reg_hit(io_sel_i, REG_CONTROL) |=> io_rdata_o[7:4] == 4'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("control reserved bits not zero");

  property p_irq_busy;
    @(posedge clock_i) disable iff (!rst_n)
      busy_reg |-> !ready_irq_o;
  endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("ready interrupt during programming");

  property p_irq_ready;
    @(posedge clock_i) disable iff (!rst_n)
      irq_en_reg && !busy_reg && $past(cpu_global_ie_i) |-> ready_irq_o;
  endproperty
  a_irq_ready: assert property (p_irq_ready)
    else $error("ready interrupt missing");

  property p_write_start;
    @(posedge clock_i) disable iff (!rst_n)
      wr_req && arm_reg && !busy_reg && !self_program_busy_i |=>
        busy_reg && prog_cnt_reg == PROG_LOAD;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("armed strobe did not start programming");

  property p_unarmed;
    @(posedge clock_i) disable iff (!rst_n)
      wr_req && !arm_reg && !busy_reg |=> !busy_reg;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("unarmed strobe started a write");

  property p_arm_timeout;
    @(posedge clock_i) disable iff (!rst_n)
      ($rose(arm_reg) && !arm_req) ##1 !arm_req [*3] |=> !arm_reg;
  endproperty
  a_arm_timeout: assert property (p_arm_timeout)
    else $error("arm did not time out after four cycles");

  property p_arm_hold;
    @(posedge clock_i) disable iff (!rst_n)
      $rose(arm_reg) |-> arm_reg [*4];
  endproperty
  a_arm_hold: assert property (p_arm_hold)
    else $error("arm window shorter than four cycles");

  property p_prog_end;
    @(posedge clock_i) disable iff (!rst_n)
      busy_reg && prog_cnt_reg == PROG_ONE |=> !busy_reg;
  endproperty
  a_prog_end: assert property (p_prog_end)
    else $error("strobe not cleared at end of programming");

  property p_write_stall;
    @(posedge clock_i) disable iff (!rst_n)
      $rose(busy_reg) |-> cpu_stall_o [*2] ##1 !cpu_stall_o;
  endproperty
  a_write_stall: assert property (p_write_stall)
    else $error("write stall not two cycles");

  property p_read_stall;
    @(posedge clock_i) disable iff (!rst_n)
      start_read ##1 !(rd_req || wr_req) [*4] |=> !cpu_stall_o &&
        $past(cpu_stall_o, 4) && $past(cpu_stall_o, 1);
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read stall not four cycles");

  property p_read_fetch;
    @(posedge clock_i) disable iff (!rst_n)
      start_read |=> ##1 data_reg == $past(mem_rdata);
  endproperty
  a_read_fetch: assert property (p_read_fetch)
    else $error("fetched byte not in data register");

  property p_addr_frozen;
    @(posedge clock_i) disable iff (!rst_n)
      busy_reg && (wr_addr_low || wr_addr_high) |=> $stable(addr_reg);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen)
    else $error("address changed during programming");

  property p_no_restart;
    @(posedge clock_i) disable iff (!rst_n)
      busy_reg && prog_cnt_reg > PROG_ONE |=>
        prog_cnt_reg == $past(prog_cnt_reg) - PROG_ONE;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("programming count disturbed");
endmodule // nvac_ctrl

// file: verif/test_nvac_ctrl.sv
// Self-checking bench for the nonvolatile byte access controller
`timescale 1ns/1ps
module test_nvac_ctrl;
  import nvac_pkg::*;
  localparam longint unsigned SIM_PROG = 60;
  logic clock_i;
  logic resetn_i;
  logic [1:0] io_sel_i;
  logic io_wr_i;
  logic io_rd_i;
  logic [7:0] io_wdata_i;
  logic cpu_global_ie_i;
  logic self_program_busy_i;
  logic [7:0] io_rdata_o;
  logic cpu_stall_o;
  logic ready_irq_o;
  logic [7:0] exp_q[$];
  logic rd_pend;
  logic [31:0] seed;
  logic [8:0] a;
  logic [7:0] d;
  int failures;
  int check_count;
  int stall_cnt;
  int irq_low_cnt;

  nvac_ctrl #(.PROG_CYCLES(SIM_PROG)) i_nvac_ctrl (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .io_sel_i(io_sel_i),
    .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i),
    .cpu_global_ie_i(cpu_global_ie_i),
    .self_program_busy_i(self_program_busy_i),
    .io_rdata_o(io_rdata_o),
    .cpu_stall_o(cpu_stall_o),
    .ready_irq_o(ready_irq_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] v);
    io_sel_i = s;
    io_wdata_i = v;
    io_wr_i = 1'b1;
    tick(1);
    io_wr_i = 1'b0;
    tick(1);
  endtask

  // Read request; the monitor compares the answer
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    io_sel_i = s;
    io_rd_i = 1'b1;
    tick(1);
    io_rd_i = 1'b0;
    tick(1);
  endtask

  task automatic set_addr(input logic [8:0] ad);
    wr(REG_ADDR_HIGH, {7'h00, ad[8]});
    wr(REG_ADDR_LOW, ad[7:0]);
  endtask

  task automatic store(input logic [8:0] ad, input logic [7:0] v,
                       input logic poke);
    set_addr(ad);
    wr(REG_DATA, v);
    wr(REG_CONTROL, 8'h0c);
    stall_cnt = 0;
    irq_low_cnt = 0;
    wr(REG_CONTROL, 8'h0a);
    tick(2);
    chk(stall_cnt, 32'h2);
    rd(REG_CONTROL, 8'h0a);
    if (poke) begin
      set_addr(~ad);
      stall_cnt = 0;
      wr(REG_CONTROL, 8'h0b);
      tick(4);
      chk(stall_cnt, 32'h0);
      wr(REG_DATA, ~v);
      wr(REG_CONTROL, 8'h0c);
      wr(REG_CONTROL, 8'h0a);
    end
    tick(int'(SIM_PROG));
    chk(irq_low_cnt, 32'(SIM_PROG));
  endtask

  task automatic fetch(input logic [8:0] ad, input logic [7:0] v);
    set_addr(ad);
    stall_cnt = 0;
    wr(REG_CONTROL, 8'h09);
    tick(4);
    chk(stall_cnt, 32'h4);
    rd(REG_DATA, v);
  endtask

  task automatic end_sim;
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read answers appear at the taking edge and are checked on the next falling edge
  always @(posedge clock_i) begin
    rd_pend <= io_rd_i;
    if (cpu_stall_o === 1'b1) stall_cnt++;
    if (ready_irq_o !== 1'b1) irq_low_cnt++;
  end

  always @(negedge clock_i) begin
    if (rd_pend === 1'b1) begin
      chk({24'h000000, io_rdata_o}, {24'h000000, exp_q.pop_front()});
    end
  end

  initial begin
    #200000;
    failures++;
    end_sim();
  end

  initial begin
    resetn_i = 1'b0;
    io_sel_i = 2'h0;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    io_wdata_i = 8'h00;
    cpu_global_ie_i = 1'b1;
    self_program_busy_i = 1'b0;
    seed = 32'h487d;
    failures = 0;
    check_count = 0;
    stall_cnt = 0;
    irq_low_cnt = 0;
    repeat (6) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    tick(3);
    wr(REG_CONTROL, 8'hf8);
    rd(REG_CONTROL, 8'h08);
    wr(REG_ADDR_HIGH, 8'hff);
    rd(REG_ADDR_HIGH, 8'h01);
    // Boundary addresses, then a random one with busy-time pokes
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      a = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : seed[16:8];
      d = seed[7:0];
      store(a, d, k == 2);
      fetch(a, d);
    end
    irq_low_cnt = 0;
    wr(REG_CONTROL, 8'h0a);
    wr(REG_CONTROL, 8'h0c);
    rd(REG_CONTROL, 8'h0c);
    rd(REG_CONTROL, 8'h0c);
    rd(REG_CONTROL, 8'h08);
    wr(REG_CONTROL, 8'h0a);
    self_program_busy_i = 1'b1;
    wr(REG_CONTROL, 8'h0c);
    wr(REG_CONTROL, 8'h0a);
    self_program_busy_i = 1'b0;
    tick(4);
    chk(irq_low_cnt, 32'h0);
    cpu_global_ie_i = 1'b0;
    tick(3);
    chk({31'h0, ready_irq_o}, 32'h0);
    cpu_global_ie_i = 1'b1;
    tick(3);
    chk({31'h0, ready_irq_o}, 32'h1);
    wr(REG_CONTROL, 8'h00);
    tick(2);
    chk({31'h0, ready_irq_o}, 32'h0);
    end_sim();
  end
endmodule // test_nvac_ctrl
